// >>> rtl/reset_source_controller.sv
// reset source controller: merges six reset sources into reset flows
//
// Behaviour
// R1 - power-on resets all, drives both pins
// R2 - straps latched only at power-on
// R3 - hard reset keeps soft reset asserted
// R4 - reset pins open-drain, also sensed
// R5 - hard reset drives pins, reloads config word
// R6 - external soft reset accepted only when idle
// R7 - soft reset drives soft pin, keeps config
// R8 - enabled watchdog expiry starts hard reset
// R9 - enabled bus monitor expiry starts hard reset
// R10 - jtag host command starts soft reset
// R11 - status records causes of latest reset
// R12 - strap sampling, pll reset only power-on
// R13 - config write windows depend on flow
// R14 - peripherals reset on every source
// R15 - board holds power-on input 16 clocks
// R16 - straps sampled at power-on release
// R17 - internal power-on ends 1024 clocks later
// R18 - hard pin released 512 after lock
// R19 - soft pin released 515 after lock
// R20 - power-on beats hard beats soft
`timescale 1ns/100ps

module reset_source_controller
    import reset_source_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     power_on_reset_n,
    input  wire logic                     hard_reset_n_in,
    output logic                          hard_reset_n_out,
    output logic                          hard_reset_n_oe,
    input  wire logic                     soft_reset_n_in,
    output logic                          soft_reset_n_out,
    output logic                          soft_reset_n_oe,
    input  wire logic                     watchdog_expired,
    input  wire logic                     watchdog_reset_enable,
    input  wire logic                     bus_monitor_expired,
    input  wire logic                     bus_monitor_reset_enable,
    input  wire logic                     jtag_soft_reset_req,
    input  wire logic                     system_pll_locked,
    input  wire strap_t                   strap_pins,
    input  wire logic                     hard_config_valid,
    input  wire logic [HARD_CONFIG_W-1:0] hard_config_word,
    output strap_t                        strap,
    output logic [HARD_CONFIG_W-1:0]      hard_config,
    output cause_t                        reset_cause,
    output domain_t                       domain_reset,
    output logic                          config_write_slave_ok,
    output logic                          config_write_bus_ok,
    output flow_t                         flow
);

    flow_t                    next_flow;
    logic [CNT_W-1:0]         count;
    logic [CNT_W-1:0]         next_count;
    logic                     por_wait;
    logic                     next_por_wait;
    logic                     hard_drive;
    logic                     next_hard_drive;
    logic                     soft_drive;
    logic                     next_soft_drive;
    logic                     por_prev;
    cause_t                   next_cause;
    strap_t                   next_strap;
    logic [HARD_CONFIG_W-1:0] next_hard_config;
    logic                     cfg_slave_ok;
    logic                     next_cfg_slave_ok;
    logic                     cfg_bus_ok;
    logic                     next_cfg_bus_ok;
    logic                     por_active;
    logic                     hard_req;
    logic                     soft_req;
    logic                     ext_hard;
    logic                     ext_soft;
    logic                     wd_req;
    logic                     bm_req;
    logic                     busy;

    assign por_active = !power_on_reset_n;
    assign wd_req     = watchdog_expired && watchdog_reset_enable;       // R8
    assign bm_req     = bus_monitor_expired && bus_monitor_reset_enable; // R9
    assign busy       = (flow != FLOW_IDLE) || hard_drive || soft_drive;
    // pin sensed low while we are not driving: someone outside pulls it
    assign ext_hard   = !hard_reset_n_in && !hard_drive;                 // R4
    assign ext_soft   = !soft_reset_n_in && !busy;                       // R6
    assign hard_req   = ext_hard || wd_req || bm_req;
    assign soft_req   = ext_soft || jtag_soft_reset_req;                 // R10

    always_comb
    begin
        next_flow         = flow;
        next_count        = count;
        next_por_wait     = por_wait;
        next_hard_drive   = hard_drive;
        next_soft_drive   = soft_drive;
        next_cause        = reset_cause;
        next_strap        = strap;
        next_hard_config  = hard_config;
        next_cfg_slave_ok = cfg_slave_ok;
        next_cfg_bus_ok   = cfg_bus_ok;
        if (por_active)                                                  // R20
        begin
            next_flow         = FLOW_POR;                                // R1
            next_por_wait     = 1'b1;
            next_count        = '0;
            next_hard_drive   = 1'b1;
            next_soft_drive   = 1'b1;
            next_cause        = '{power_on: 1'b1, default: 1'b0};        // R11
            next_hard_config  = HARD_CONFIG_RESET;
            next_cfg_slave_ok = 1'b1;                                    // R13
            next_cfg_bus_ok   = 1'b1;
        end
        else if (hard_req && flow != FLOW_POR && flow != FLOW_HARD)      // R20
        begin
            next_flow         = FLOW_HARD;                               // R5
            next_count        = '0;
            next_hard_drive   = 1'b1;
            next_soft_drive   = 1'b1;                                    // R3
            next_cause        = '{hard_ext: ext_hard, watchdog: wd_req,
                                  bus_monitor: bm_req, default: 1'b0};   // R11
            next_cfg_slave_ok = 1'b0;                                    // R13
            next_cfg_bus_ok   = 1'b1;
        end
        else if (soft_req && flow == FLOW_IDLE)
        begin
            next_flow         = FLOW_SOFT;                               // R7
            next_count        = '0;
            next_soft_drive   = 1'b1;
            next_cause        = '{soft_ext: ext_soft, jtag: jtag_soft_reset_req,
                                  default: 1'b0};                        // R11
            next_cfg_slave_ok = 1'b0;                                    // R13
            next_cfg_bus_ok   = 1'b0;
        end
        else
        begin
            // one load path: the bus window output decides, so the two agree except in a hard flow started by a hard source, where only the bus window is open
            if (hard_config_valid && config_write_bus_ok)                // R13
            begin
                next_hard_config = hard_config_word;                     // R5
            end
            case (flow)
                FLOW_POR:
                begin
                    if (por_prev)
                    begin
                        next_strap = strap_pins;                         // R16
                    end
                    if (por_wait)
                    begin
                        next_count = count + 1'b1;
                        if (count == CNT_W'(POR_RELEASE_CYCLES - 1))     // R17
                        begin
                            next_por_wait = 1'b0;
                            next_count    = '0;
                        end
                    end
                    else
                    begin
                        next_flow = FLOW_HARD;
                    end
                end
                FLOW_HARD, FLOW_SOFT:
                begin
                    if (system_pll_locked)
                    begin
                        next_count = count + 1'b1;
                        if (count == CNT_W'(HARD_RELEASE_CYCLES - 1))    // R18
                        begin
                            next_hard_drive = 1'b0;
                        end
                        if (count == CNT_W'(SOFT_RELEASE_CYCLES - 1))    // R19
                        begin
                            next_soft_drive = 1'b0;
                            next_flow       = FLOW_IDLE;
                            next_count      = '0;
                        end
                    end
                end
                default:
                begin
                    next_count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flow         <= FLOW_IDLE;
            count        <= '0;
            por_wait     <= 1'b0;
            hard_drive   <= 1'b0;
            soft_drive   <= 1'b0;
            por_prev     <= 1'b0;
            reset_cause  <= '0;
            strap        <= STRAP_RESET;                                 // R2
            hard_config  <= HARD_CONFIG_RESET;
            cfg_slave_ok <= 1'b0;
            cfg_bus_ok   <= 1'b0;
        end
        else
        begin
            flow         <= next_flow;
            count        <= next_count;
            por_wait     <= next_por_wait;
            hard_drive   <= next_hard_drive;
            soft_drive   <= next_soft_drive;
            por_prev     <= por_active;
            reset_cause  <= next_cause;
            strap        <= next_strap;                                  // R12
            hard_config  <= next_hard_config;
            cfg_slave_ok <= next_cfg_slave_ok;
            cfg_bus_ok   <= next_cfg_bus_ok;
        end
    end

    // open drain: data always low, enable pulls the pin
    assign hard_reset_n_out = 1'b0;                                      // R4
    assign soft_reset_n_out = 1'b0;
    assign hard_reset_n_oe  = hard_drive;
    // soft drive is set with every hard drive and outlives it
    assign soft_reset_n_oe  = soft_drive;                                // R3

    assign domain_reset = '{pll_reset:        por_active || por_wait,    // R12
                            cores_reset:      soft_drive || hard_drive,
                            periph_reset:     soft_drive || hard_drive,  // R14
                            sys_config_reset: hard_drive};
    assign config_write_slave_ok = cfg_slave_ok && flow != FLOW_IDLE;    // R13
    assign config_write_bus_ok   = cfg_bus_ok && flow != FLOW_IDLE;

endmodule

// >>> rtl/reset_source_pkg.sv
// package for the reset source controller: counts, config layout, flows
package reset_source_pkg;

    localparam int unsigned POR_RELEASE_CYCLES  = 1024;
    localparam int unsigned HARD_RELEASE_CYCLES = 512;
    localparam int unsigned SOFT_RELEASE_CYCLES = 515;
    localparam int unsigned CNT_W               = 11;
    localparam int unsigned HARD_CONFIG_W       = 32;
    localparam logic [HARD_CONFIG_W-1:0] HARD_CONFIG_RESET = 32'h0000_0000;

    // sampled strap group, fourteen levels in total
    typedef struct packed {
        logic       reset_config_select;
        logic       config_slave;
        logic       slave_sync;
        logic       slave_wide_port;
        logic [3:0] chip_identifier;
        logic [2:0] boot_mode;
        logic       watchdog_enable;
        logic [1:0] clock_mode_select;
    } strap_t;

    localparam strap_t STRAP_RESET = '0;

    // status bits: which sources caused the latest reset
    typedef struct packed {
        logic power_on;
        logic hard_ext;
        logic soft_ext;
        logic watchdog;
        logic bus_monitor;
        logic jtag;
    } cause_t;

    // reset outputs to the rest of the chip
    typedef struct packed {
        logic pll_reset;
        logic cores_reset;
        logic periph_reset;
        logic sys_config_reset;
    } domain_t;

    typedef enum logic [1:0] {
        FLOW_IDLE,
        FLOW_POR,
        FLOW_HARD,
        FLOW_SOFT
    } flow_t;

endpackage

// >>> sim/reset_source_controller_chk.sv
// port assertions for the reset source controller
`timescale 1ns/100ps
module reset_source_controller_chk
    import reset_source_pkg::*;
(
    input wire logic    clk,
    input wire logic    rst_n,
    input wire logic    power_on_reset_n,
    input wire logic    hard_reset_n_out,
    input wire logic    hard_reset_n_oe,
    input wire logic    soft_reset_n_in,
    input wire logic    soft_reset_n_out,
    input wire logic    soft_reset_n_oe,
    input wire logic    watchdog_expired,
    input wire logic    watchdog_reset_enable,
    input wire logic    jtag_soft_reset_req,
    input wire strap_t  strap,
    input wire cause_t  reset_cause,
    input wire domain_t domain_reset,
    input wire logic    config_write_slave_ok,
    input wire logic    config_write_bus_ok,
    input wire flow_t   flow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_por_drives: assert property (!power_on_reset_n |=> flow == FLOW_POR)
        else $error("power-on flow not started");
    a_hard_soft: assert property (hard_reset_n_oe |-> soft_reset_n_oe)
        else $error("hard drive without soft drive");
    a_open_drain: assert property (!hard_reset_n_out && !soft_reset_n_out)
        else $error("reset pin data not low");
    a_strap_held: assert property (flow != FLOW_POR |=> $stable(strap))
        else $error("straps changed outside power-on");
    a_wdog_hard: assert property (watchdog_expired && watchdog_reset_enable &&
        power_on_reset_n && flow == FLOW_IDLE |=> flow == FLOW_HARD && reset_cause.watchdog)
        else $error("watchdog expiry did not start hard flow");
    a_jtag_soft: assert property (jtag_soft_reset_req && flow == FLOW_IDLE
        |=> flow != FLOW_IDLE && soft_reset_n_oe)
        else $error("jtag request did not start a flow");
    a_soft_refused: assert property ($rose(reset_cause.soft_ext)
        |-> $past(flow) == FLOW_IDLE && !$past(soft_reset_n_oe))
        else $error("external soft taken during own drive");
    a_slave_window: assert property (config_write_slave_ok
        |-> reset_cause.power_on && flow inside {FLOW_POR, FLOW_HARD})
        else $error("slave config window open outside power-on");
    a_bus_window: assert property (config_write_bus_ok |-> flow inside {FLOW_POR, FLOW_HARD})
        else $error("bus config window open outside power-on or hard");
    a_pll_por: assert property (domain_reset.pll_reset |-> !power_on_reset_n || flow == FLOW_POR)
        else $error("pll reset outside power-on");
    a_periph_any: assert property (flow != FLOW_IDLE |-> domain_reset.periph_reset &&
        domain_reset.cores_reset)
        else $error("peripherals not in reset during a flow");
    a_soft_tail: assert property ($fell(hard_reset_n_oe) && flow != FLOW_IDLE
        |-> soft_reset_n_oe [*3] ##1 !soft_reset_n_oe && flow == FLOW_IDLE)
        else $error("soft release not three cycles after hard");

    c_por: cover property (flow == FLOW_POR ##1 flow == FLOW_HARD);
    c_soft: cover property (flow == FLOW_SOFT);
    c_wdog: cover property (flow == FLOW_HARD && reset_cause.watchdog);
endmodule

bind reset_source_controller reset_source_controller_chk i_chk (.*);

// >>> sim/reset_board_model.sv
// board side: power-on driver, pulled-up open-drain pins, pll lock
`timescale 1ns/100ps
module reset_board_model #(parameter int LOCK_DELAY = 1100)
(
    input  wire logic clk,
    input  wire logic por_start,
    input  wire logic ext_hard,
    input  wire logic ext_soft,
    input  wire logic hard_reset_n_oe,
    input  wire logic soft_reset_n_oe,
    output logic      power_on_reset_n,
    output logic      hard_reset_n_in,
    output logic      soft_reset_n_in,
    output logic      system_pll_locked
);
    int hold = 0;
    int lock = 0;
    // pull-ups: a released line reads high, never the last level
    assign hard_reset_n_in = !(hard_reset_n_oe || ext_hard);
    assign soft_reset_n_in = !(soft_reset_n_oe || ext_soft);
    assign power_on_reset_n = (hold == 0);
    assign system_pll_locked = (lock >= LOCK_DELAY);
    always @(posedge clk)
    begin
        if (por_start)
            hold <= 16;
        else if (hold != 0)
            hold <= hold - 1;
        // lock lands after the internal power-on wait, so the 512 count is seen
        if (!power_on_reset_n)
            lock <= 0;
        else if (lock < LOCK_DELAY)
            lock <= lock + 1;
    end
endmodule

// >>> sim/test_reset_source_controller.sv
// self-checking bench for the reset source controller
`timescale 1ns/100ps
module test_reset_source_controller
    import reset_source_pkg::*;
    ;
    typedef struct packed { flow_t f; cause_t c; cause_t m; } note_t;
    note_t   q[$];
    note_t   nt;
    logic    clk = 0, rst_n = 0, por_start = 0, ext_hard = 0, ext_soft = 0;
    logic    watchdog_expired = 0, watchdog_reset_enable = 0, bus_monitor_expired = 0;
    logic    bus_monitor_reset_enable = 0, jtag_soft_reset_req = 0, hard_config_valid = 0;
    logic    power_on_reset_n, hard_reset_n_in, soft_reset_n_in, system_pll_locked;
    logic    hard_reset_n_out, hard_reset_n_oe, soft_reset_n_out, soft_reset_n_oe;
    logic    config_write_slave_ok, config_write_bus_ok;
    logic    [HARD_CONFIG_W-1:0] hard_config_word = '0, hard_config, word;
    strap_t  strap_pins = '0, strap, st;
    cause_t  reset_cause;
    domain_t domain_reset;
    flow_t   flow, last = FLOW_IDLE;
    int      err_total = 0, total_checks = 0, cyc = 0, n_cyc;
    integer  seed = 32'h8019;

    reset_source_controller i_reset_source_controller (.*);
    reset_board_model i_reset_board_model (.*);

    initial forever #10 clk = ~clk;

    task automatic chk(input bit ok, input string m);
        total_checks++;
        if (!ok)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // sources held three cycles so repeats inside a flow are refused too
    task automatic fire(input logic [4:0] s, input flow_t f, input cause_t c, input cause_t m);
        if (f != FLOW_IDLE)
        begin
            q.push_back('{f, c, m});
            q.push_back('{FLOW_IDLE, c, m});
        end
        {ext_hard, ext_soft, watchdog_expired, bus_monitor_expired, jtag_soft_reset_req} <= s;
        hard_config_valid <= s[0] & ~s[2];
        hard_config_word <= ~hard_config_word;
        repeat (3) @(posedge clk);
        {ext_hard, ext_soft, watchdog_expired, bus_monitor_expired, jtag_soft_reset_req} <= '0;
        hard_config_valid <= 0;
        while (q.size() != 0) @(posedge clk);
        repeat (4) @(posedge clk);
        $display("test %b done", s);
    endtask

    always @(negedge clk)
    begin
        if (rst_n && flow !== last)
        begin
            last = flow;
            if (q.size() == 0)
                chk(0, "unexpected flow change");
            else
            begin
                nt = q.pop_front();
                chk(flow === nt.f && (reset_cause & nt.m) === (nt.c & nt.m), "flow or cause");
            end
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            err_total++;
            wrap_up();
        end
    end

    initial
    begin
        word = $random(seed);
        st = word[13:0];
        repeat (16) @(posedge clk);
        rst_n <= 1;
        strap_pins <= st;
        q.push_back('{FLOW_POR, 6'h20, 6'h3f});
        q.push_back('{FLOW_HARD, 6'h20, 6'h3f});
        q.push_back('{FLOW_IDLE, 6'h20, 6'h3f});
        @(posedge clk);
        por_start <= 1;
        @(posedge clk);
        por_start <= 0;
        hard_config_word <= word;
        // the board pulls power-on low at the edge above; it reads low from this edge on
        @(posedge clk);
        while (!power_on_reset_n) @(posedge clk);
        hard_config_valid <= 1;
        @(posedge clk);
        hard_config_valid <= 0;
        n_cyc = 0;
        while (flow !== FLOW_HARD)
        begin
            @(posedge clk);
            n_cyc++;
        end
        chk(n_cyc >= 1022 && n_cyc <= 1026, "internal power-on length");
        strap_pins <= ~st;
        while (!system_pll_locked) @(posedge clk);
        n_cyc = 0;
        while (hard_reset_n_oe === 1'b1)
        begin
            @(posedge clk);
            n_cyc++;
        end
        chk(n_cyc >= 511 && n_cyc <= 513, "hard release after lock");
        while (q.size() != 0) @(posedge clk);
        chk(strap === st && hard_config === word, "power-on latch");
        $display("test power-on done");
        fire(5'b00110, FLOW_IDLE, 6'h00, 6'h00);
        watchdog_reset_enable <= 1;
        bus_monitor_reset_enable <= 1;
        fire(5'b00100, FLOW_HARD, 6'h04, 6'h3f);
        fire(5'b00010, FLOW_HARD, 6'h02, 6'h3f);
        fire(5'b00001, FLOW_SOFT, 6'h01, 6'h3f);
        fire(5'b10000, FLOW_HARD, 6'h10, 6'h3f);
        fire(5'b01000, FLOW_SOFT, 6'h08, 6'h3f);
        fire(5'b01101, FLOW_HARD, 6'h04, 6'h04);
        chk(strap === st && hard_config === word, "config kept");
        wrap_up();
    end
endmodule
